// *** rtl/acq_trigger_clock_sequencer.v ***
`timescale 1ns/10ps
`default_nettype none
`include "acq_trigger_clock_sequencer_defines.vh"

module acq_trigger_clock_sequencer #(
	parameter CNT_W    = 32,
	parameter PERIOD_W = 24,
	parameter CHAN_W   = 6
) (
	// Clock, reset, enable
	input  wire                core_clk,
	input  wire                reset,
	input  wire                clk_en,
	// External pins
	input  wire                in_trigger_pin,
	input  wire                in_ext_clock_pin,
	input  wire                out_trigger_pin,
	input  wire                out_ext_clock_pin,
	// Input procedure settings
	input  wire                in_start,
	input  wire                in_stop,
	input  wire [1:0]          in_trigger_mode_select,
	input  wire                in_whole_list_clock_select,
	input  wire                in_ext_clock_select,
	input  wire                counter_expansion_used,
	input  wire [PERIOD_W-1:0] in_period_cycles,
	input  wire [CHAN_W-1:0]   in_list_length,
	input  wire [1:0]          in_first_chan_type,
	input  wire [CNT_W-1:0]    in_sample_count,
	// Output procedure settings
	input  wire                out_start,
	input  wire                out_stop,
	input  wire [1:0]          out_trigger_mode_select,
	input  wire                out_whole_list_clock_select,
	input  wire                out_ext_clock_select,
	input  wire [PERIOD_W-1:0] out_period_cycles,
	input  wire [CHAN_W-1:0]   out_list_length,
	input  wire [CNT_W-1:0]    out_update_count,
	// Input sequencing results
	output reg                 sample_strobe,
	output reg  [CHAN_W-1:0]   sample_chan,
	output reg                 in_running,
	output reg                 in_done,
	output reg  [PERIOD_W-1:0] analog_cycles,
	output reg  [PERIOD_W-1:0] effective_in_period,
	// Output sequencing results
	output reg                 update_strobe,
	output reg  [CHAN_W-1:0]   update_chan,
	output reg                 out_running,
	output reg                 out_done
);

	localparam [4:0] ST_IDLE = 5'h01;
	localparam [4:0] ST_ARM  = 5'h02;
	localparam [4:0] ST_PAD  = 5'h04;
	localparam [4:0] ST_RUN  = 5'h08;
	localparam [4:0] ST_WAIT = 5'h10;

	// Limits kept at full width, then cut to the period width
	localparam [31:0]         ANALOG_MIN_W  = `ANALOG_MIN_CYC;
	localparam [31:0]         DIGITAL_MIN_W = `DIGITAL_MIN_CYC;
	localparam [31:0]         CT_MIN_W      = `CT_MIN_CYC;
	localparam [PERIOD_W-1:0] ANALOG_MIN    = ANALOG_MIN_W[PERIOD_W-1:0];
	localparam [PERIOD_W-1:0] DIGITAL_MIN   = DIGITAL_MIN_W[PERIOD_W-1:0];
	localparam [PERIOD_W-1:0] CT_MIN        = CT_MIN_W[PERIOD_W-1:0];

	// Two-stage synchronisers then edge history
	reg [1:0] in_trig_sync;
	reg [1:0] in_clk_sync;
	reg [1:0] out_trig_sync;
	reg [1:0] out_clk_sync;
	reg       in_trig_last;
	reg       in_clk_last;
	reg       out_trig_last;
	reg       out_clk_last;

	always @(posedge core_clk) begin
		if (reset) begin
			in_trig_sync  <= 2'h0;
			in_clk_sync   <= 2'h0;
			out_trig_sync <= 2'h0;
			out_clk_sync  <= 2'h0;
			in_trig_last  <= 1'b0;
			in_clk_last   <= 1'b0;
			out_trig_last <= 1'b0;
			out_clk_last  <= 1'b0;
		end else if (clk_en) begin
			in_trig_sync  <= {in_trig_sync[0], in_trigger_pin};
			in_clk_sync   <= {in_clk_sync[0], in_ext_clock_pin};
			out_trig_sync <= {out_trig_sync[0], out_trigger_pin};
			out_clk_sync  <= {out_clk_sync[0], out_ext_clock_pin};
			in_trig_last  <= in_trig_sync[1];
			in_clk_last   <= in_clk_sync[1];
			out_trig_last <= out_trig_sync[1];
			out_clk_last  <= out_clk_sync[1];
		end
	end

	// Pin to edge takes two cycles, inside the latency budget
	wire in_trig_level = in_trig_sync[1];
	wire in_trig_rise  = in_trig_sync[1] & ~in_trig_last;
	wire in_clk_rise   = in_clk_sync[1] & ~in_clk_last;
	wire out_trig_lvl  = out_trig_sync[1];
	wire out_trig_rise = out_trig_sync[1] & ~out_trig_last;
	wire out_clk_rise  = out_clk_sync[1] & ~out_clk_last;

	// Input period limits and analog cycle count
	reg [PERIOD_W-1:0] next_eff_period;
	reg [PERIOD_W-1:0] next_analog_cycles;
	always @* begin
		next_eff_period = in_period_cycles;
		if (next_eff_period < DIGITAL_MIN)
			next_eff_period = DIGITAL_MIN;
		if (counter_expansion_used && next_eff_period < CT_MIN)
			next_eff_period = CT_MIN;
		next_analog_cycles = (ANALOG_MIN + next_eff_period - 1'b1) / next_eff_period;
	end

	// Input sequencer
	reg [4:0]          in_state;
	reg [PERIOD_W-1:0] in_timer;
	reg [CHAN_W-1:0]   in_chan;
	reg [CNT_W-1:0]    in_taken;
	reg                in_pad_done;
	reg                in_fresh;

	wire in_gated   = (in_trigger_mode_select == `TRIG_MODE_GATED);
	wire in_trig_on = (in_trigger_mode_select != `TRIG_MODE_OFF);
	wire in_last_ch = (in_chan == in_list_length - 1'b1);
	wire in_tick    = in_ext_clock_select ? in_clk_rise : (in_timer == {PERIOD_W{1'b0}});
	// Gated stop is decided where a new list or channel would begin
	wire in_unit_start = in_whole_list_clock_select ? (in_chan == {CHAN_W{1'b0}}) : 1'b1;
	wire in_count_hit = (in_sample_count != {CNT_W{1'b0}}) &&
		(in_taken + 1'b1 >= in_sample_count);
	// Single-shot aligns to a rising edge; external clock starts on next edge
	wire in_go = in_ext_clock_select ?
		((!in_trig_on || in_trig_level) && in_clk_rise) :
		(!in_trig_on || in_trig_rise);

	always @(posedge core_clk) begin
		if (reset) begin
			in_state            <= ST_IDLE;
			in_timer            <= {PERIOD_W{1'b0}};
			in_chan             <= {CHAN_W{1'b0}};
			in_taken            <= {CNT_W{1'b0}};
			in_pad_done         <= 1'b0;
			in_fresh            <= 1'b0;
			sample_strobe       <= 1'b0;
			sample_chan         <= {CHAN_W{1'b0}};
			in_running          <= 1'b0;
			in_done             <= 1'b0;
			analog_cycles       <= {PERIOD_W{1'b0}};
			effective_in_period <= {PERIOD_W{1'b0}};
		end else if (clk_en) begin
			sample_strobe       <= 1'b0;
			analog_cycles       <= next_analog_cycles;
			effective_in_period <= next_eff_period;
			if (in_timer != {PERIOD_W{1'b0}})
				in_timer <= in_timer - 1'b1;
			case (in_state)
			ST_IDLE: begin
				if (in_start) begin
					in_state    <= ST_ARM;
					in_chan     <= {CHAN_W{1'b0}};
					in_taken    <= {CNT_W{1'b0}};
					in_done     <= 1'b0;
					in_pad_done <= 1'b0;
				end
			end
			ST_ARM, ST_WAIT: begin
				if (in_stop) begin
					in_state <= ST_IDLE;
				end else if (in_go) begin
					in_running <= 1'b1;
					in_fresh   <= 1'b1;
					// Pad one period when a counter leads the list
					if (in_first_chan_type == `CHAN_COUNTER && !in_pad_done) begin
						in_state <= ST_PAD;
						in_timer <= next_eff_period - 1'b1;
					end else begin
						in_state <= ST_RUN;
						in_timer <= {PERIOD_W{1'b0}};
					end
				end
			end
			ST_PAD: begin
				if (in_timer == {PERIOD_W{1'b0}}) begin
					in_state    <= ST_RUN;
					in_pad_done <= 1'b1;
				end
			end
			ST_RUN: begin
				if (in_stop) begin
					in_state   <= ST_IDLE;
					in_running <= 1'b0;
				end else if (in_tick || (in_ext_clock_select && sample_chan != in_chan &&
					in_whole_list_clock_select && in_chan != {CHAN_W{1'b0}} &&
					in_timer == {PERIOD_W{1'b0}})) begin
					if (in_gated && !in_trig_level && in_unit_start && !in_fresh) begin
						// Trigger low: halt without taking another sample
						in_state   <= ST_WAIT;
						in_running <= 1'b0;
					end else begin
						sample_strobe <= 1'b1;
						sample_chan   <= in_chan;
						in_fresh      <= 1'b0;
						in_taken      <= in_taken + 1'b1;
						in_timer      <= next_eff_period - 1'b1;
						in_chan       <= in_last_ch ? {CHAN_W{1'b0}} : in_chan + 1'b1;
						// Count of zero runs until stopped
						if (in_count_hit) begin
							in_state   <= ST_IDLE;
							in_running <= 1'b0;
							in_done    <= 1'b1;
						end
					end
				end
			end
			default: in_state <= ST_IDLE;
			endcase
		end
	end

	// Output sequencer
	reg [4:0]          out_state;
	reg [PERIOD_W-1:0] out_timer;
	reg [CHAN_W-1:0]   out_chan;
	reg [CNT_W-1:0]    out_taken;
	reg                out_list_busy;
	reg                out_fresh;

	wire out_gated    = (out_trigger_mode_select == `TRIG_MODE_GATED);
	wire out_trig_on  = (out_trigger_mode_select != `TRIG_MODE_OFF);
	wire out_last_ch  = (out_chan == out_list_length - 1'b1);
	wire out_timer_up = (out_timer == {PERIOD_W{1'b0}});
	// External edge starts a list or one channel; rest of list follows period
	wire out_tick = out_ext_clock_select ?
		(out_clk_rise || (out_list_busy && out_timer_up)) : out_timer_up;
	// Whole-list output may only halt before channel 0
	wire out_unit_start = out_whole_list_clock_select ? (out_chan == {CHAN_W{1'b0}}) : 1'b1;
	wire out_count_hit = (out_update_count != {CNT_W{1'b0}}) &&
		(out_taken + 1'b1 >= out_update_count);
	wire out_go = !out_trig_on || out_trig_rise;

	always @(posedge core_clk) begin
		if (reset) begin
			out_state     <= ST_IDLE;
			out_timer     <= {PERIOD_W{1'b0}};
			out_chan      <= {CHAN_W{1'b0}};
			out_taken     <= {CNT_W{1'b0}};
			out_list_busy <= 1'b0;
			out_fresh     <= 1'b0;
			update_strobe <= 1'b0;
			update_chan   <= {CHAN_W{1'b0}};
			out_running   <= 1'b0;
			out_done      <= 1'b0;
		end else if (clk_en) begin
			update_strobe <= 1'b0;
			if (!out_timer_up)
				out_timer <= out_timer - 1'b1;
			case (out_state)
			ST_IDLE: begin
				if (out_start) begin
					out_state     <= ST_ARM;
					out_chan      <= {CHAN_W{1'b0}};
					out_taken     <= {CNT_W{1'b0}};
					out_done      <= 1'b0;
					out_list_busy <= 1'b0;
				end
			end
			ST_ARM, ST_WAIT: begin
				if (out_stop) begin
					out_state <= ST_IDLE;
				end else if (out_go) begin
					out_state   <= ST_RUN;
					out_running <= 1'b1;
					out_fresh   <= 1'b1;
					out_timer   <= {PERIOD_W{1'b0}};
				end
			end
			ST_RUN: begin
				if (out_stop) begin
					out_state     <= ST_IDLE;
					out_running   <= 1'b0;
					out_list_busy <= 1'b0;
				end else if (out_tick && (out_ext_clock_select ? (out_clk_rise ||
					out_list_busy) : 1'b1)) begin
					if (out_gated && !out_trig_lvl && out_unit_start && !out_fresh) begin
						// Trigger low: halt without another update
						out_state     <= ST_WAIT;
						out_running   <= 1'b0;
						out_list_busy <= 1'b0;
					end else begin
						update_strobe <= 1'b1;
						update_chan   <= out_chan;
						out_fresh     <= 1'b0;
						out_taken     <= out_taken + 1'b1;
						out_timer     <= out_period_cycles - 1'b1;
						out_chan      <= out_last_ch ? {CHAN_W{1'b0}} : out_chan + 1'b1;
						out_list_busy <= out_whole_list_clock_select && !out_last_ch;
						// Count of zero runs until stopped
						if (out_count_hit) begin
							out_state   <= ST_IDLE;
							out_running <= 1'b0;
							out_done    <= 1'b1;
						end
					end
				end
			end
			default: out_state <= ST_IDLE;
			endcase
		end
	end

endmodule // acq_trigger_clock_sequencer
`default_nettype wire

// *** rtl/acq_trigger_clock_sequencer_defines.vh ***
`ifndef ACQ_TRIGGER_CLOCK_SEQUENCER_DEFINES_VH
`define ACQ_TRIGGER_CLOCK_SEQUENCER_DEFINES_VH
`define CLK_PERIOD_PS          32'd25000
`define ANALOG_MIN_PS          32'd1250000
`define DIGITAL_MIN_PS         32'd600000
`define CT_MIN_PS              32'd3000000
`define SYNC_LATENCY_NS        32'd200
`define TRIG_MIN_HIGH_NS       32'd60
`define TRIG_SINGLE_MAX_NS     32'd250
`define ANALOG_MIN_CYC         ((`ANALOG_MIN_PS + `CLK_PERIOD_PS - 32'd1) / `CLK_PERIOD_PS)
`define DIGITAL_MIN_CYC        ((`DIGITAL_MIN_PS + `CLK_PERIOD_PS - 32'd1) / `CLK_PERIOD_PS)
`define CT_MIN_CYC             ((`CT_MIN_PS + `CLK_PERIOD_PS - 32'd1) / `CLK_PERIOD_PS)
`define SYNC_LATENCY_CYC       ((`SYNC_LATENCY_NS * 32'd1000) / `CLK_PERIOD_PS)
`define TRIG_MODE_OFF          2'h0
`define TRIG_MODE_SINGLE_SHOT  2'h1
`define TRIG_MODE_GATED        2'h2
`define CHAN_ANALOG            2'h0
`define CHAN_DIGITAL           2'h1
`define CHAN_COUNTER           2'h2
`endif

// *** verification/acq_trigger_clock_sequencer_chk.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "acq_trigger_clock_sequencer_defines.vh"
module acq_seq_chk #(
	parameter CNT_W    = 32,
	parameter PERIOD_W = 24,
	parameter CHAN_W   = 6
) (
	// Clock and reset
	input wire logic                core_clk,
	input wire logic                reset,
	// Pins and settings
	input wire logic                in_trigger_pin,
	input wire logic                out_ext_clock_pin,
	input wire logic                in_start,
	input wire logic                out_start,
	input wire logic [1:0]          in_trigger_mode_select,
	input wire logic [1:0]          out_trigger_mode_select,
	input wire logic                in_whole_list_clock_select,
	input wire logic                in_ext_clock_select,
	input wire logic                out_ext_clock_select,
	input wire logic                counter_expansion_used,
	input wire logic [PERIOD_W-1:0] in_period_cycles,
	input wire logic [CHAN_W-1:0]   in_list_length,
	input wire logic [1:0]          in_first_chan_type,
	// Results
	input wire logic                sample_strobe,
	input wire logic [CHAN_W-1:0]   sample_chan,
	input wire logic                in_running,
	input wire logic [PERIOD_W-1:0] analog_cycles,
	input wire logic [PERIOD_W-1:0] effective_in_period,
	input wire logic                update_strobe,
	input wire logic [CHAN_W-1:0]   update_chan
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	logic [7:0] gap;
	logic       in_armed;
	logic       out_armed;
	// Cycles since the last sample, saturating
	always @(posedge core_clk) begin
		if (reset || in_start) gap <= 8'hFF;
		else if (sample_strobe) gap <= 8'h01;
		else if (gap != 8'hFF) gap <= gap + 8'h01;
		if (reset || sample_strobe) in_armed <= 1'b0;
		else if (in_start && in_trigger_mode_select == `TRIG_MODE_SINGLE_SHOT && !in_ext_clock_select)
			in_armed <= 1'b1;
		if (reset || update_strobe) out_armed <= 1'b0;
		else if (out_start && out_ext_clock_select) out_armed <= 1'b1;
	end
	a_sample_spacing: assert property (sample_strobe |-> gap >= 8'd24)
		else $error("samples closer than the minimum period");
	a_period_floor: assert property (in_running |-> effective_in_period >=
		(counter_expansion_used ? PERIOD_W'(`CT_MIN_CYC) : PERIOD_W'(`DIGITAL_MIN_CYC)))
		else $error("effective period below its floor");
	a_analog_count: assert property (in_running && !counter_expansion_used && in_period_cycles >= 24
		|-> analog_cycles == PERIOD_W'((`ANALOG_MIN_CYC + in_period_cycles - 1) / in_period_cycles))
		else $error("analog cycle count not rounded up");
	a_off_start: assert property (in_start && !in_running && !in_ext_clock_select
		&& in_trigger_mode_select == `TRIG_MODE_OFF && in_first_chan_type != `CHAN_COUNTER
		|-> ##[2:4] (sample_strobe && sample_chan == 0))
		else $error("untriggered input did not start");
	a_single_shot_trigger_waits: assert property (in_start && !in_ext_clock_select
		&& in_trigger_mode_select == `TRIG_MODE_SINGLE_SHOT ##1 !in_trigger_pin [*8]
		|-> !sample_strobe && !in_running)
		else $error("single-shot input ran without trigger");
	a_single_shot_trigger_align: assert property (in_armed && $rose(in_trigger_pin) |-> ##[2:6] sample_strobe)
		else $error("first sample not aligned to trigger");
	a_gated_finish: assert property (sample_strobe && in_whole_list_clock_select
		&& in_trigger_mode_select == `TRIG_MODE_GATED && sample_chan != in_list_length - 1
		|-> ##[1:130] sample_strobe)
		else $error("gated stop inside a channel list");
	a_out_off_start: assert property (out_start && !out_ext_clock_select
		&& out_trigger_mode_select == `TRIG_MODE_OFF |-> ##[2:4] (update_strobe && update_chan == 0))
		else $error("untriggered output did not start");
	a_out_first_edge: assert property (out_armed && $rose(out_ext_clock_pin) |-> ##[2:6] update_strobe)
		else $error("first external output edge dropped");
	cover property (sample_strobe && in_trigger_mode_select == `TRIG_MODE_GATED);
	cover property (in_armed && $rose(in_trigger_pin));
	cover property (update_strobe && out_ext_clock_select);
endmodule // acq_seq_chk
bind acq_trigger_clock_sequencer acq_seq_chk #(.CNT_W(CNT_W), .PERIOD_W(PERIOD_W), .CHAN_W(CHAN_W))
	chk (.core_clk, .reset, .in_trigger_pin, .out_ext_clock_pin, .in_start, .out_start,
	.in_trigger_mode_select, .out_trigger_mode_select, .in_whole_list_clock_select,
	.in_ext_clock_select, .out_ext_clock_select, .counter_expansion_used, .in_period_cycles,
	.in_list_length, .in_first_chan_type, .sample_strobe, .sample_chan, .in_running,
	.analog_cycles, .effective_in_period, .update_strobe, .update_chan);
`default_nettype wire

// *** verification/ext_source_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module ext_source_model (
	// Sampling clock
	input wire logic core_clk,
	// Pins toward the sequencer
	output logic     in_trigger_pin,
	output logic     in_ext_clock_pin,
	output logic     out_trigger_pin,
	output logic     out_ext_clock_pin
);
	initial begin
		{in_trigger_pin, in_ext_clock_pin, out_trigger_pin, out_ext_clock_pin} = 4'h0;
	end
	// Trigger held at least 60 ns; at most 250 ns for a single step
	task automatic pulse(input bit out_side, input int high_ns);
		@(negedge core_clk);
		if (out_side) out_trigger_pin = 1'b1; else in_trigger_pin = 1'b1;
		#(high_ns);
		if (out_side) out_trigger_pin = 1'b0; else in_trigger_pin = 1'b0;
	endtask
	// 200 ns clock edges, idle gap keeps period above update time plus latency
	task automatic clk_edges(input int n, input int gap);
		repeat (n) begin
			@(negedge core_clk);
			out_ext_clock_pin = 1'b1;
			#100 out_ext_clock_pin = 1'b0;
			#100;
			repeat (gap) @(negedge core_clk);
		end
	endtask
endmodule // ext_source_model
`default_nettype wire

// *** verification/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
	$display("BAD %0t got %0h expected %0h", $time, g, e); end end
module testbench;
	logic        core_clk, reset, clk_en, in_start, in_stop, in_whole_list_clock_select;
	logic        in_ext_clock_select, counter_expansion_used, out_start, out_stop;
	logic        out_whole_list_clock_select, out_ext_clock_select;
	logic [1:0]  in_trigger_mode_select, out_trigger_mode_select, in_first_chan_type;
	logic [23:0] in_period_cycles, out_period_cycles, effective_in_period, analog_cycles;
	logic [5:0]  in_list_length, out_list_length, sample_chan, update_chan;
	logic [31:0] in_sample_count, out_update_count;
	logic        sample_strobe, in_running, in_done, update_strobe, out_running, out_done;
	wire         in_trigger_pin, in_ext_clock_pin, out_trigger_pin, out_ext_clock_pin;
	int          fails = 0, n_compared = 0, cycles = 0, n_in, n_out, k;
	acq_trigger_clock_sequencer dut (.core_clk, .reset, .clk_en, .in_trigger_pin,
		.in_ext_clock_pin, .out_trigger_pin, .out_ext_clock_pin, .in_start, .in_stop,
		.in_trigger_mode_select, .in_whole_list_clock_select, .in_ext_clock_select,
		.counter_expansion_used, .in_period_cycles, .in_list_length, .in_first_chan_type,
		.in_sample_count, .out_start, .out_stop, .out_trigger_mode_select,
		.out_whole_list_clock_select, .out_ext_clock_select, .out_period_cycles,
		.out_list_length, .out_update_count, .sample_strobe, .sample_chan, .in_running,
		.in_done, .analog_cycles, .effective_in_period, .update_strobe, .update_chan,
		.out_running, .out_done);
	ext_source_model src (.core_clk, .in_trigger_pin, .in_ext_clock_pin, .out_trigger_pin,
		.out_ext_clock_pin);
	always #12.5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 6000) begin
			fails++;
			test_done();
		end
	end
	task automatic test_done;
		if (fails == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic pulse_ctl(input bit out_side, input bit stop);
		@(negedge core_clk);
		{out_start, in_start, out_stop, in_stop} = 4'h1 << {!stop, out_side};
		@(negedge core_clk);
		{out_start, in_start, out_stop, in_stop} = 4'h0;
	endtask
	// Counts strobes; optionally checks channel order from channel 0
	task automatic watch(input int cyc, input bit chan);
		n_in = 0;
		n_out = 0;
		repeat (cyc) begin
			@(negedge core_clk);
			if (sample_strobe === 1'b1) begin
				if (chan) `CHK(sample_chan, 6'(n_in % in_list_length))
				n_in++;
			end
			if (update_strobe === 1'b1) begin
				if (chan) `CHK(update_chan, 6'(n_out % out_list_length))
				n_out++;
			end
		end
	endtask
	task automatic t_input_off;
		`CHK({in_running, in_done, out_running, out_done}, 4'h0)
		{in_period_cycles, in_list_length, in_sample_count} = {24'h00001E, 6'h03, 32'h6};
		pulse_ctl(0, 0);
		`CHK(effective_in_period, 24'h00001E)
		`CHK(analog_cycles, 24'h000002)
		watch(260, 1);
		`CHK(n_in, 6)
		`CHK(in_done, 1'b1)
	endtask
	task automatic t_counter_first;
		{in_period_cycles, in_sample_count, counter_expansion_used} = {24'h00000A, 32'h2, 1'b1};
		in_first_chan_type = 2'h2;
		pulse_ctl(0, 0);
		for (k = 0; k < 300 && sample_strobe !== 1'b1; k++) @(negedge core_clk);
		`CHK(effective_in_period, 24'h000078)
		`CHK(k > 120, 1'b1)
		{counter_expansion_used, in_first_chan_type} = 3'h1;
		watch(200, 0);
		pulse_ctl(0, 0);
		repeat (4) @(negedge core_clk);
		`CHK(effective_in_period, 24'h000018)
		watch(60, 0);
	endtask
	task automatic t_input_trig;
		{in_period_cycles, in_sample_count, in_trigger_mode_select} = {24'h000018, 32'h4, 2'h1};
		pulse_ctl(0, 0);
		watch(20, 0);
		`CHK(n_in, 0)
		fork src.pulse(0, 100); watch(150, 0); join
		`CHK(n_in, 4)
		{in_sample_count, in_trigger_mode_select, in_whole_list_clock_select} = {32'h0, 3'h4};
		pulse_ctl(0, 0);
		fork src.pulse(0, 100); watch(100, 0); join
		`CHK(n_in, 1)
		pulse_ctl(0, 1);
		in_whole_list_clock_select = 1'b1;
		pulse_ctl(0, 0);
		fork src.pulse(0, 750); watch(200, 1); join
		`CHK(n_in, 3)
		fork src.pulse(0, 100); watch(150, 1); join
		`CHK(n_in, 3)
		pulse_ctl(0, 1);
	endtask
	task automatic t_output;
		pulse_ctl(1, 0);
		watch(120, 1);
		`CHK({n_out, out_done}, {32'h3, 1'b1})
		{out_update_count, out_trigger_mode_select} = {32'h2, 2'h1};
		pulse_ctl(1, 0);
		fork src.pulse(1, 100); watch(80, 1); join
		`CHK(n_out, 2)
		{out_update_count, out_trigger_mode_select, out_ext_clock_select} = {32'h0, 3'h1};
		out_whole_list_clock_select = 1'b0;
		out_list_length = 6'h03;
		pulse_ctl(1, 0);
		fork src.clk_edges(3, 40); watch(180, 1); join
		`CHK(n_out, 3)
		pulse_ctl(1, 1);
		{out_whole_list_clock_select, out_list_length} = {1'b1, 6'h02};
		pulse_ctl(1, 0);
		fork src.clk_edges(2, 60); watch(150, 1); join
		`CHK(n_out, 4)
		pulse_ctl(1, 1);
	endtask
	initial begin
		{core_clk, reset, clk_en, in_start, in_stop, in_ext_clock_select} = 6'h18;
		{counter_expansion_used, out_start, out_stop, out_ext_clock_select} = 4'h0;
		{in_whole_list_clock_select, out_whole_list_clock_select} = 2'h3;
		{in_trigger_mode_select, out_trigger_mode_select, in_first_chan_type} = 6'h01;
		{out_period_cycles, out_list_length, out_update_count} = {24'h000018, 6'h02, 32'h3};
		{in_period_cycles, in_list_length, in_sample_count} = {24'h000018, 6'h03, 32'h1};
		repeat (3) @(negedge core_clk);
		reset = 1'b0;
		t_input_off();
		t_counter_first();
		t_input_trig();
		t_output();
		test_done();
	end
endmodule // testbench
`default_nettype wire
